// *** src/nand_host_ctrl.sv ***
// How it works
// - Command byte latched on write rising, CLE high.
// - Address byte latched on write rising, ALE high.
// - Host sends five address cycles.
// - Column then row bytes, pads driven low.
// - Host sets latch levels per cycle type.
// - During busy only status and reset commands pulse the write strobe.
`timescale 1ns/1ns
`default_nettype none

module nand_host_ctrl
	import nand_host_pkg::*;
#(
	parameter int PHASE = PHASE_CYC,
	parameter int WP_SETUP = WP_SETUP_CYC
)
(
	// Clock and reset.
	input  wire logic                  sys_clk,
	input  wire logic                  rst_n,
	// User request.
	input  wire logic                  req_valid,
	input  wire logic [1:0]            req_op,
	input  wire logic [7:0]            req_byte,
	input  wire logic [COL_BITS-1:0]   column_addr_bits,
	input  wire logic [ROW_BITS-1:0]   row_addr_bits,
	input  wire logic                  prog_enable,
	output logic                       req_ready,
	// User answer.
	output logic                       rsp_valid,
	output logic [7:0]                 rsp_byte,
	output logic                       cmd_refused,
	output logic                       dev_busy,
	// Device pins.
	output logic                       chip_sel_n,
	output logic                       cmd_latch,
	output logic                       addr_latch,
	output logic                       write_strobe_n,
	output logic                       output_strobe_n,
	output logic                       write_prot_n,
	output logic [7:0]                 io_out,
	output logic                       io_oe,
	input  wire logic [7:0]            io_in,
	input  wire logic                  ready_busy_n
);

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_LOW,
		ST_HIGH,
		ST_RD_LOW,
		ST_RD_HIGH
	} state_t;

	state_t     state_r;
	logic [7:0] timer_r;          // Phase timer.
	logic [2:0] acyc_r;           // Address cycle index.
	logic [1:0] op_r;             // Operation in flight.
	logic [7:0] data_r;           // Byte to drive for command or data.
	logic [7:0] wp_cnt_r;         // Cycles since write protect went high, saturating at WP_SETUP.
	logic       rb_sync_r;        // Ready/busy sample.
	logic [7:0] addr_byte;

	// Address bytes come from a separate packer.
	nand_addr_pack u_pack (
		.sys_clk          (sys_clk),
		.rst_n            (rst_n),
		.column_addr_bits (column_addr_bits),
		.row_addr_bits    (row_addr_bits),
		.cycle_idx        (acyc_r),
		.addr_byte        (addr_byte)
	);

	// Commands legal while busy.
	function automatic logic busy_ok(input logic [7:0] c);
		busy_ok = (c == CMD_STATUS) || (c == CMD_STATUS_MULTI) || (c == CMD_RESET);
	endfunction

	// Program and erase confirm codes and the data input codes need write protect high.
	function automatic logic needs_wp(input logic [7:0] c);
		needs_wp = (c == CMD_PROG_GO) || (c == CMD_PROG_CACHE) || (c == CMD_PROG_PLANE)
			|| (c == CMD_ERASE_GO) || (c == CMD_DATA_IN) || (c == CMD_PLANE_IN)
			|| (c == CMD_COPY_PROG);
	endfunction

	wire req_op_cmd   = (req_op == OP_CMD);
	wire req_op_write = (req_op == OP_WRITE);
	wire busy_now     = !rb_sync_r;
	// Busy accepts only the three codes; everything else is refused.
	wire refuse_busy  = req_op_cmd ? (busy_now && !busy_ok(req_byte)) : busy_now;
	// Program/erase and data input need write protect released and settled.
	wire wp_ready     = wp_cnt_r >= WP_SETUP[7:0];
	wire refuse_wp    = (req_op_cmd && needs_wp(req_byte)) || req_op_write
		? !(prog_enable && wp_ready) : 1'b0;
	wire take         = (state_r == ST_IDLE) && req_valid;
	wire accept       = take && !refuse_busy && !refuse_wp;
	wire phase_done   = (timer_r == 8'h00);
	wire is_addr      = (op_r == OP_ADDR);
	wire last_addr    = (acyc_r == 3'(ADDR_CYCLES - 1));

	// Ready/busy sampled; inputs are synchronous to sys_clk.
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			rb_sync_r <= 1'b0;
		else
			rb_sync_r <= ready_busy_n;
	end

	// Write protect follows prog_enable and counts its setup time.
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			write_prot_n <= 1'b0;
			wp_cnt_r     <= 8'h00;
		end
		else
		begin
			write_prot_n <= prog_enable;
			if (!prog_enable)
				wp_cnt_r <= 8'h00;
			else if (!wp_ready)
				wp_cnt_r <= wp_cnt_r + 8'h01;
		end
	end

	// Main sequencer: one strobe phase per low and high half.
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_r         <= ST_IDLE;
			timer_r         <= 8'h00;
			acyc_r          <= 3'h0;
			op_r            <= OP_CMD;
			data_r          <= 8'h00;
			chip_sel_n      <= 1'b1;
			cmd_latch       <= 1'b0;
			addr_latch      <= 1'b0;
			write_strobe_n  <= 1'b1;
			output_strobe_n <= 1'b1;
			io_out          <= 8'h00;
			io_oe           <= 1'b0;
			req_ready       <= 1'b0;
			rsp_valid       <= 1'b0;
			rsp_byte        <= 8'h00;
			cmd_refused     <= 1'b0;
			dev_busy        <= 1'b1;
		end
		else
		begin
			rsp_valid   <= 1'b0;
			cmd_refused <= 1'b0;
			dev_busy    <= busy_now;
			if (!phase_done)
				timer_r <= timer_r - 8'h01;
			case (state_r)
				ST_IDLE:
				begin
					// Strobes rest high; chip select released lets a ready device idle.
					write_strobe_n  <= 1'b1;
					output_strobe_n <= 1'b1;
					cmd_latch       <= 1'b0;
					addr_latch      <= 1'b0;
					io_oe           <= 1'b0;
					chip_sel_n      <= 1'b1;
					req_ready       <= 1'b1;
					if (take && !accept)
					begin
						cmd_refused <= 1'b1;
						req_ready   <= 1'b0;
					end
					else if (accept)
					begin
						req_ready    <= 1'b0;
						op_r         <= op_t'(req_op);
						data_r       <= req_byte;
						acyc_r       <= 3'h0;
						chip_sel_n   <= 1'b0;
						timer_r      <= PHASE[7:0];
						if (req_op == OP_READ)
							state_r <= ST_RD_LOW;
						else
							state_r <= ST_LOW;
					end
				end
				ST_LOW:
				begin
					// Set latch levels for the cycle type, then pull write strobe low.
					cmd_latch      <= (op_r == OP_CMD);
					addr_latch     <= is_addr;
					io_out         <= is_addr ? addr_byte : data_r;
					io_oe          <= 1'b1;
					// The packer's byte is registered, so the bus is stale for the first cycle.
					// Holding the strobe high then keeps a wrong byte off a low write strobe.
					write_strobe_n <= (timer_r == PHASE[7:0]);
					if (phase_done)
					begin
						timer_r <= PHASE[7:0];
						state_r <= ST_HIGH;
					end
				end
				ST_HIGH:
				begin
					// Rising write strobe latches the byte; latches hold through the rise.
					write_strobe_n <= 1'b1;
					if (phase_done)
					begin
						if (is_addr && !last_addr)
						begin
							acyc_r  <= acyc_r + 3'h1;
							timer_r <= PHASE[7:0];
							state_r <= ST_LOW;
						end
						else
						begin
							rsp_valid <= 1'b1;
							state_r   <= ST_IDLE;
						end
					end
				end
				ST_RD_LOW:
				begin
					// Bus released; falling output strobe fetches the next byte.
					io_oe           <= 1'b0;
					output_strobe_n <= 1'b0;
					if (phase_done)
					begin
						rsp_byte <= io_in;
						timer_r  <= PHASE[7:0];
						state_r  <= ST_RD_HIGH;
					end
				end
				ST_RD_HIGH:
				begin
					output_strobe_n <= 1'b1;
					if (phase_done)
					begin
						rsp_valid <= 1'b1;
						state_r   <= ST_IDLE;
					end
				end
				default:
					state_r <= ST_IDLE;
			endcase
		end
	end

	// Latches are never both high and write strobe only falls with the bus driven.
	property p_latch_excl;
		@(posedge sys_clk) disable iff (!rst_n)
		!(cmd_latch && addr_latch);
	endproperty
	a_latch_excl: assert property (p_latch_excl) else $error("both latches high");

	property p_we_drives;
		@(posedge sys_clk) disable iff (!rst_n)
		!write_strobe_n |-> io_oe && !chip_sel_n && output_strobe_n;
	endproperty
	a_we_drives: assert property (p_we_drives) else $error("write strobe without drive");

	property p_re_float;
		@(posedge sys_clk) disable iff (!rst_n)
		!output_strobe_n |-> !io_oe && write_strobe_n && !cmd_latch && !addr_latch;
	endproperty
	a_re_float: assert property (p_re_float) else $error("bus driven during read");

	property p_busy_refuse;
		@(posedge sys_clk) disable iff (!rst_n)
		take && busy_now && req_op_cmd && !busy_ok(req_byte) |=> cmd_refused && state_r == ST_IDLE;
	endproperty
	a_busy_refuse: assert property (p_busy_refuse) else $error("busy command not refused");

	property p_wp_block;
		@(posedge sys_clk) disable iff (!rst_n)
		take && req_op_cmd && req_byte == CMD_ERASE_GO && !write_prot_n |=> cmd_refused;
	endproperty
	a_wp_block: assert property (p_wp_block) else $error("erase under protect");

	property p_five_addr;
		@(posedge sys_clk) disable iff (!rst_n)
		accept && req_op == OP_ADDR |=> acyc_r == 3'h0
			##[1:300] (acyc_r == 3'h4 && addr_latch);
	endproperty
	a_five_addr: assert property (p_five_addr) else $error("address cycles short");

	property p_addr_pad;
		@(posedge sys_clk) disable iff (!rst_n)
		addr_latch && !write_strobe_n && acyc_r == 3'h4 |-> io_out[7:2] == 6'h00;
	endproperty
	a_addr_pad: assert property (p_addr_pad) else $error("row pad bits set");

	property p_strobe_idle;
		@(posedge sys_clk) disable iff (!rst_n)
		state_r == ST_IDLE ##1 state_r == ST_IDLE |-> write_strobe_n && output_strobe_n;
	endproperty
	a_strobe_idle: assert property (p_strobe_idle) else $error("strobe low while idle");

endmodule
`default_nettype wire

// *** src/nand_host_pkg.sv ***
package nand_host_pkg;

	// Command codes, with bus line 8 as the most significant bit.
	localparam logic [7:0] CMD_READ_SETUP    = 8'h00;
	localparam logic [7:0] CMD_READ_START    = 8'h30;
	localparam logic [7:0] CMD_COL_OUT_SETUP = 8'h05;
	localparam logic [7:0] CMD_COL_OUT_GO    = 8'hE0;
	localparam logic [7:0] CMD_READ_CACHE    = 8'h31;
	localparam logic [7:0] CMD_READ_LAST     = 8'h3F;
	localparam logic [7:0] CMD_DATA_IN       = 8'h80;
	localparam logic [7:0] CMD_PLANE_IN      = 8'h81;
	localparam logic [7:0] CMD_PROG_GO       = 8'h10;
	localparam logic [7:0] CMD_PROG_PLANE    = 8'h11;
	localparam logic [7:0] CMD_PROG_CACHE    = 8'h15;
	localparam logic [7:0] CMD_COL_IN_CHANGE = 8'h85;
	localparam logic [7:0] CMD_COPY_READ     = 8'h3A;
	localparam logic [7:0] CMD_COPY_PROG     = 8'h8C;
	localparam logic [7:0] CMD_ERASE_SETUP   = 8'h60;
	localparam logic [7:0] CMD_ERASE_GO      = 8'hD0;
	localparam logic [7:0] CMD_ID_READ       = 8'h90;
	localparam logic [7:0] CMD_STATUS        = 8'h70;
	localparam logic [7:0] CMD_STATUS_MULTI  = 8'h71;
	localparam logic [7:0] CMD_RESET         = 8'hFF;

	// Address layout.
	localparam int ADDR_CYCLES   = 5;
	localparam int COL_BITS      = 13;
	localparam int ROW_BITS      = 18;
	localparam int PAGE_BITS     = 6;
	localparam int BLOCK_BITS    = 12;
	localparam int PAGE_BYTES    = 4352;
	localparam int MAIN_BYTES    = 4096;
	localparam int SPARE_BYTES   = 256;
	localparam int BLOCK_PAGES   = 64;

	// Pass/fail bit of the status byte.
	localparam int STAT_FAIL_BIT = 0;

	// Strobe phase time in ns and derived cycles at 100 MHz (least time, rounded up).
	localparam int CLK_PERIOD_NS = 10;
	localparam int PHASE_NS      = 30;
	localparam int PHASE_CYC     = (PHASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// Write protect high to first write strobe.
	localparam int WP_SETUP_NS   = 100;
	localparam int WP_SETUP_CYC  = (WP_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Operation kinds the user requests.
	typedef enum logic [1:0] {
		OP_CMD,
		OP_ADDR,
		OP_WRITE,
		OP_READ
	} op_t;

endpackage

// *** src/nand_addr_pack.sv ***
`timescale 1ns/1ns
`default_nettype none

// Splits column and row into the five address bytes and registers the selected byte.
module nand_addr_pack
	import nand_host_pkg::*;
(
	// Clock and reset.
	input  wire logic                 sys_clk,
	input  wire logic                 rst_n,
	// Address fields and cycle index.
	input  wire logic [COL_BITS-1:0]  column_addr_bits,
	input  wire logic [ROW_BITS-1:0]  row_addr_bits,
	input  wire logic [2:0]           cycle_idx,
	// Registered address byte.
	output logic      [7:0]           addr_byte
);

	// Pad bits in cycles two and five are always driven low.
	wire [7:0] byte0 = column_addr_bits[7:0];
	wire [7:0] byte1 = {3'h0, column_addr_bits[12:8]};
	wire [7:0] byte2 = row_addr_bits[7:0];
	wire [7:0] byte3 = row_addr_bits[15:8];
	wire [7:0] byte4 = {6'h00, row_addr_bits[17:16]};

	// Selection is combinational; only the chosen byte is stored.
	logic [7:0] sel_byte;
	always_comb
	begin
		case (cycle_idx)
			3'h0: sel_byte = byte0;
			3'h1: sel_byte = byte1;
			3'h2: sel_byte = byte2;
			3'h3: sel_byte = byte3;
			default: sel_byte = byte4;
		endcase
	end

	// Register the byte so the bus sees a clean value.
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			addr_byte <= 8'h00;
		else
			addr_byte <= sel_byte;
	end

endmodule
`default_nettype wire

// *** test/nand_dev_model.sv ***
`timescale 1ns/1ns
`default_nettype none

// Strobe-driven flash device; it has no clock, so capture and output follow pin edges and busy ends after a fixed delay.
module nand_dev_model
(
	// Host pins.
	input  wire logic       chip_sel_n,
	input  wire logic       cmd_latch,
	input  wire logic       addr_latch,
	input  wire logic       write_strobe_n,
	input  wire logic       output_strobe_n,
	input  wire logic       write_prot_n,
	input  wire logic [7:0] bus_in,
	// Device side.
	output logic [7:0]      dq,
	output logic            ready_busy_n,
	output logic            standby,
	output logic [7:0]      last_cmd,
	output logic [7:0]      addr_q [5]
);
	logic [12:0] col;      // Column counter.
	logic        busy;     // An array operation is running.
	logic [7:0]  last_out; // Last byte presented on the bus.
	logic [2:0]  addr_cnt; // Address cycles taken since the last command.

	// The read setup code counts as latched at power-on.
	initial
	begin
		last_cmd = 8'h00;
		addr_cnt = 3'h0;
		busy = 1'b0;
		col = 13'h0000;
		last_out = 8'h00;
	end

	// Command and address capture on the write strobe rising edge.
	always @(posedge write_strobe_n)
	begin
		// Busy device takes only status and reset.
		if (!chip_sel_n && cmd_latch && !addr_latch && (!busy || bus_in == 8'h70 ||
			bus_in == 8'h71 || bus_in == 8'hFF))
		begin
			last_cmd = bus_in;
			addr_cnt = 3'h0;
			// Array read start.
			if (bus_in == 8'h30)
			begin
				busy = 1'b1;
				busy <= #500 1'b0;
			end
			// Program or erase runs only with write protect high.
			if ((bus_in == 8'h10 || bus_in == 8'hD0) && write_prot_n)
			begin
				busy = 1'b1;
				busy <= #800 1'b0;
			end
		end
		else if (!chip_sel_n && addr_latch && !cmd_latch && !busy && addr_cnt < 3'h5)
		begin
			addr_q[addr_cnt] = bus_in;
			addr_cnt = addr_cnt + 3'h1;
			col = {addr_q[1][4:0], addr_q[0]};
		end
	end

	// Each output strobe fall while selected and ready presents a byte and, unless the last command is a status code, steps the column.
	always @(negedge output_strobe_n)
	begin
		if (!chip_sel_n && !busy)
		begin
			// Status keeps the pass/fail bit on bus line 1 at zero: no page ever fails here.
			last_out = (last_cmd == 8'h70) ? {write_prot_n, 1'b1, 6'h00} : (col[7:0] ^ 8'hA5);
			// Status output does not move the data column.
			if (last_cmd != 8'h70 && last_cmd != 8'h71)
				col = (col == 13'd4351) ? 13'h0000 : col + 13'h0001;
		end
	end

	// A released bus shows the inverse of the last byte, so a late sample fails.
	assign dq = (!chip_sel_n && !output_strobe_n && !cmd_latch && !addr_latch && write_strobe_n)
		? last_out : ~last_out;
	// Open-drain ready line with the pull-up folded in.
	assign ready_busy_n = !busy;
	// Standby only when deselected and ready; busy ignores chip select.
	assign standby = chip_sel_n && !busy;
endmodule
`default_nettype wire

// *** test/tb_nand_command_address_port.sv ***
`timescale 1ns/1ns
`default_nettype none

module tb_nand_command_address_port
	import nand_host_pkg::*;
;
	logic sys_clk = 1'b0, rst_n = 1'b0, req_valid = 1'b0, prog_enable = 1'b0;
	logic [1:0] req_op = 2'h0;
	logic [7:0] req_byte = 8'h00;
	logic [COL_BITS-1:0] col_s = '0;
	logic [ROW_BITS-1:0] row_s = '0;
	logic req_ready, rsp_valid, cmd_refused, dev_busy, chip_sel_n, cmd_latch, addr_latch;
	logic write_strobe_n, output_strobe_n, write_prot_n, io_oe, ready_busy_n, standby;
	logic [7:0] rsp_byte, io_out, dq, last_cmd;
	logic [7:0] addr_q [5];
	int num_errors = 0, check_count = 0;
	logic [7:0] codes [20] = '{CMD_READ_SETUP, CMD_READ_START, CMD_COL_OUT_SETUP, CMD_COL_OUT_GO,
		CMD_READ_CACHE, CMD_READ_LAST, CMD_DATA_IN, CMD_PLANE_IN, CMD_PROG_GO, CMD_PROG_PLANE,
		CMD_PROG_CACHE, CMD_COL_IN_CHANGE, CMD_COPY_READ, CMD_COPY_PROG, CMD_ERASE_SETUP,
		CMD_ERASE_GO, CMD_ID_READ, CMD_STATUS, CMD_STATUS_MULTI, CMD_RESET};

	// Free-running system clock.
	always #5 sys_clk = ~sys_clk;

	nand_host_ctrl i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .req_valid(req_valid),
		.req_op(req_op), .req_byte(req_byte), .column_addr_bits(col_s), .row_addr_bits(row_s),
		.prog_enable(prog_enable), .req_ready(req_ready), .rsp_valid(rsp_valid),
		.rsp_byte(rsp_byte), .cmd_refused(cmd_refused), .dev_busy(dev_busy),
		.chip_sel_n(chip_sel_n), .cmd_latch(cmd_latch), .addr_latch(addr_latch),
		.write_strobe_n(write_strobe_n), .output_strobe_n(output_strobe_n),
		.write_prot_n(write_prot_n), .io_out(io_out), .io_oe(io_oe), .io_in(dq),
		.ready_busy_n(ready_busy_n));

	nand_dev_model i_dev (.chip_sel_n(chip_sel_n), .cmd_latch(cmd_latch),
		.addr_latch(addr_latch), .write_strobe_n(write_strobe_n),
		.output_strobe_n(output_strobe_n), .write_prot_n(write_prot_n), .bus_in(io_out),
		.dq(dq), .ready_busy_n(ready_busy_n), .standby(standby), .last_cmd(last_cmd),
		.addr_q(addr_q));

	// Expected address byte for each of the five cycles.
	function automatic logic [7:0] addr_exp(input logic [12:0] c, input logic [17:0] r, input int i);
		case (i)
			0: return c[7:0];
			1: return {3'h0, c[12:8]};
			2: return r[7:0];
			3: return r[15:8];
			default: return {6'h00, r[17:16]};
		endcase
	endfunction

	task automatic report_and_stop();
		$display("Checks %0d, errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
		check_count++;
		if (got !== exp)
		begin
			num_errors++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic check1(input string what, input logic exp, input logic got);
		check8(what, {7'h00, exp}, {7'h00, got});
	endtask

	// One bounded clock wait; a hang counts as a mismatch and ends the run.
	task automatic tick(inout int n);
		@(posedge sys_clk);
		#1;
		n++;
		if (n > 400)
		begin
			num_errors++;
			$display("Error wait bound ran out");
			report_and_stop();
		end
	endtask

	// Issues one request and checks whether it was refused.
	task automatic do_op(input op_t op, input logic [7:0] b, input logic refuse);
		int n;
		n = 0;
		while (req_ready !== 1'b1)
			tick(n);
		@(posedge sys_clk);
		req_valid <= 1'b1;
		req_op <= op;
		req_byte <= b;
		@(posedge sys_clk);
		req_valid <= 1'b0;
		// A refusal pulse stands for one cycle only, so look right after this edge.
		#1;
		while (rsp_valid !== 1'b1 && cmd_refused !== 1'b1)
			tick(n);
		check1("refused", refuse, cmd_refused);
	endtask

	// Waits until the device is busy, then until it is ready again.
	task automatic busy_then_ready();
		int n;
		n = 0;
		while (dev_busy !== 1'b1)
			tick(n);
		check1("standby while busy", 1'b0, standby);
		while (dev_busy !== 1'b0 || ready_busy_n !== 1'b1)
			tick(n);
	endtask

	initial
	begin
		void'($urandom(32'hdfadee01));
		repeat (4) @(posedge sys_clk);
		rst_n <= 1'b1;
		check1("write protect at reset", 1'b0, write_prot_n);
		check1("chip select at reset", 1'b1, chip_sel_n);
		// Program setup and erase confirm without write enable must be refused.
		do_op(OP_CMD, CMD_DATA_IN, 1'b1);
		do_op(OP_CMD, CMD_ERASE_GO, 1'b1);
		prog_enable <= 1'b1;
		repeat (12) @(posedge sys_clk);
		// Random addresses, the last column and the last row among them.
		for (int k = 0; k < 4; k++)
		begin
			@(posedge sys_clk);
			col_s <= (k == 0) ? 13'd4351 : 13'($urandom % 4352);
			row_s <= (k == 1) ? 18'h3_FFFF : 18'($urandom);
			do_op(OP_CMD, CMD_READ_SETUP, 1'b0);
			do_op(OP_ADDR, 8'h00, 1'b0);
			for (int i = 0; i < 5; i++)
				check8("address byte", addr_exp(col_s, row_s, i), addr_q[i]);
			check8("page in block", {2'h0, row_s[5:0]}, {2'h0, addr_q[2][5:0]});
			// Chip select is released one edge after the answer.
			@(posedge sys_clk);
			#1;
			check1("standby when idle", 1'b1, standby);
			check1("bus released when idle", 1'b0, io_oe);
		end
		do_op(OP_CMD, CMD_READ_START, 1'b0);
		do_op(OP_CMD, CMD_STATUS, 1'b0);
		do_op(OP_CMD, CMD_DATA_IN, 1'b1);
		busy_then_ready();
		do_op(OP_READ, 8'h00, 1'b0);
		check8("status byte", 8'hC0, rsp_byte);
		do_op(OP_CMD, CMD_READ_SETUP, 1'b0);
		for (int k = 0; k < 3; k++)
		begin
			do_op(OP_READ, 8'h00, 1'b0);
			check8("read byte", 8'(col_s + 13'(k)) ^ 8'hA5, rsp_byte);
		end
		// Page program with random data.
		do_op(OP_CMD, CMD_DATA_IN, 1'b0);
		do_op(OP_ADDR, 8'h00, 1'b0);
		repeat (3) do_op(OP_WRITE, 8'($urandom), 1'b0);
		do_op(OP_CMD, CMD_PROG_GO, 1'b0);
		busy_then_ready();
		// Every command code, latched with bus line 8 as the top bit.
		foreach (codes[i])
		begin
			do_op(OP_CMD, codes[i], 1'b0);
			check8("latched command", codes[i], last_cmd);
			if (codes[i] == CMD_READ_START || codes[i] == CMD_PROG_GO || codes[i] == CMD_ERASE_GO)
				busy_then_ready();
		end
		report_and_stop();
	end
endmodule
`default_nettype wire
